// file: core/bds_ports.sv
// Purpose: Read/write port logic of a four-word-burst double-rate SRAM
// Assumes: clk_i edges alternate positive / negative input clock rises
// Notes:   Output clocks coincide with input clocks in this model
//
// Contract
// RULE1: Separate read-only output port and write-only input port, no turnaround.
// RULE2: One shared address bus, read and write addresses at different times.
// RULE3: Four internal arrays of 18-bit words; every access moves four words.
// RULE4: Latency one and a half cycles with pll_disable_n high, one when low.
// RULE5: Reads and writes start only on a positive input clock rise.
// RULE6: Write data captured on both positive and negative input clock rises.
// RULE7: Read data leaves through registers on output clock rises.
// RULE8: Selects and byte selects registered on input clock rises.
// RULE9: Read starts on read_select_n low; address goes to read address register.
// RULE10: First word after next positive rise, then one word per output rise.
// RULE11: Read on two consecutive positive rises: second one ignored.
// RULE12: Reads every other positive rise stream data without gaps.
// RULE13: Deselected read port finishes pending reads, then tristates read_bus.
// RULE14: Write starts on write_select_n low with address on shared bus.
// RULE15: Four write words latched from next positive rise, byte selects mask.
// RULE16: All four words collected, the 72-bit burst is committed at its address.
// RULE17: Write on two consecutive positive rises: second one discarded.
// RULE18: Writes every other positive rise accept a word on every edge.
// RULE19: Deselected write port finishes bursts, then ignores write inputs.
// RULE20: Both selects from idle start the read first, then alternate.
// RULE21: Read right after write to same place returns the newest data.
// RULE22: After reset both ports deselected and read_bus high impedance.
// RULE23: Board straps single-clock mode at power-on; not changeable later.
// RULE24: Controller drives the active-low selects low to request or qualify.
`timescale 1ns/1ps
`include "bds_consts.svh"

module bds_ports
  import bds_pkg::*;
#(
  parameter int ADDR_W = `BDS_ADDR_W
)
(
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     srst_i,
  // Mode strap
  input  wire logic                     pll_disable_n_i,
  // Shared address and port selects
  input  wire logic [ADDR_W-1:0]        addr_i,
  input  wire logic                     read_select_n_i,
  input  wire logic                     write_select_n_i,
  input  wire logic [`BDS_LANES-1:0]    byte_write_select_n_i,
  // Write port
  input  wire logic [`BDS_WORD_W-1:0]   write_bus_i,
  // Read port, oe_n low while driving
  output logic      [`BDS_WORD_W-1:0]   read_bus_o,
  output logic                          read_bus_oe_n_o,
  output logic                          read_valid_o,
  input  wire logic                     read_ready_i
);

  // Elaboration check on the array depth
  if (ADDR_W < 1 || ADDR_W > 20)
  begin : g_bad_addr_w
    $error("bds_ports: ADDR_W out of range");
  end

  localparam int DEPTH = 1 << ADDR_W;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Lane-masked merge; a lane is replaced where its select is low
  function automatic bds_word_type lane_merge(input bds_word_type old_w,
                                              input bds_word_type new_w,
                                              input logic [`BDS_LANES-1:0] sel_n);
    bds_word_type res;
    res = old_w;
    for (int l = 0; l < `BDS_LANES; l++)
    begin
      if (!sel_n[l])
        res[l*`BDS_LANE_W +: `BDS_LANE_W] = new_w[l*`BDS_LANE_W +: `BDS_LANE_W];
    end
    return res;
  endfunction

  // ****************************************************************
  // Phase, strap and storage
  // ****************************************************************

  bds_phase_type               phase;
  logic                        lat_legacy;
  logic                        strap_done;
  bds_word_type                mem [`BDS_BURST][DEPTH];  // RULE3
  logic [`BDS_RD_DEPTH-1:0]    rd_tok;
  logic [ADDR_W-1:0]           rd_addr [`BDS_RD_DEPTH];
  logic [`BDS_WR_DEPTH-1:0]    wr_tok;
  logic [ADDR_W-1:0]           wr_addr [`BDS_WR_DEPTH];
  bds_word_type                wcol [`BDS_BURST];
  logic [`BDS_LANES-1:0]       wsel_n [`BDS_BURST];
  logic [ADDR_W-1:0]           wcol_addr [`BDS_BURST];
  logic [`BDS_BURST-1:0]       wvalid;
  logic                        skid_valid;
  bds_word_type                skid_data;
  logic                        read_go;
  logic                        write_go;
  logic                        in_ready;
  logic                        push;
  bds_word_type                push_data;
  logic                        commit_en;
  logic [1:0]                  rd_hist;

  // Alternating edge phase; first edge after reset is a positive rise
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      phase <= BDS_PH_POS;
    else
      phase <= (phase == BDS_PH_POS) ? BDS_PH_NEG : BDS_PH_POS;
  end

  // Latency mode caught once after reset release; fixed during operation
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      strap_done <= 1'b0;
      lat_legacy <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_done <= 1'b1;
      lat_legacy <= ~pll_disable_n_i;  // RULE4
    end
  end

  // ****************************************************************
  // Request arbitration
  // ****************************************************************

  // Skid slot free means the read word path can advance
  assign in_ready = ~skid_valid;

  // A read needs no read two edges back; frozen path refuses new reads
  // Write loses to a read on the same rise; read wins from idle
  always_comb
  begin
    read_go  = (phase == BDS_PH_POS) && !read_select_n_i   // RULE5 RULE9 RULE8
               && !rd_hist[1] && in_ready;                 // RULE11
    write_go = (phase == BDS_PH_POS) && !write_select_n_i  // RULE14 RULE2
               && !wr_tok[1] && !read_go;                  // RULE17 RULE20
  end

  // ****************************************************************
  // Read path
  // ****************************************************************

  // Read token line; frozen during a receiver stall so no word is lost
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      rd_tok <= '0;
    else if (in_ready)
      rd_tok <= {rd_tok[`BDS_RD_DEPTH-2:0], read_go};  // RULE12
  end

  // Real-time read history; a stall freezes the token line but not the clock
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      rd_hist <= '0;
    else
      rd_hist <= {rd_hist[0], read_go};  // RULE11
  end

  // Read address register and its pipeline copies
  always_ff @(posedge clk_i)
  begin
    if (in_ready)
    begin
      rd_addr[0] <= addr_i;  // RULE9
      for (int j = 1; j < `BDS_RD_DEPTH; j++)
        rd_addr[j] <= rd_addr[j-1];
    end
  end

  // Pick the word due now; newest uncommitted write data is forwarded
  always_comb
  begin
    int base;
    int k;
    base      = lat_legacy ? int'(`BDS_LAT_LEGACY) - 1 : int'(`BDS_LAT_PLL) - 1;  // RULE4
    k         = 0;
    push      = 1'b0;
    push_data = '0;
    for (int j = 0; j < `BDS_RD_DEPTH; j++)
    begin
      k = j - base;
      if (k >= 0 && k < `BDS_BURST && rd_tok[j] && in_ready)
      begin
        push      = 1'b1;                                         // RULE10
        push_data = mem[k][rd_addr[j]];
        if (wvalid[k] && wcol_addr[k] == rd_addr[j])
          push_data = lane_merge(push_data, wcol[k], wsel_n[k]);  // RULE21
      end
    end
  end

  // Two-entry output stage: head register drives the pins, skid holds overflow
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      read_valid_o    <= 1'b0;
      read_bus_oe_n_o <= 1'b1;  // RULE22
      skid_valid      <= 1'b0;
      read_bus_o      <= '0;
      skid_data       <= '0;
    end
    else if (!read_valid_o || read_ready_i)
    begin
      if (skid_valid)
      begin
        read_bus_o      <= skid_data;
        read_valid_o    <= 1'b1;
        read_bus_oe_n_o <= 1'b0;
        skid_valid      <= 1'b0;
      end
      else
      begin
        read_bus_o      <= push ? push_data : read_bus_o;  // RULE7 RULE1
        read_valid_o    <= push;
        read_bus_oe_n_o <= ~push;                          // RULE13
      end
    end
    else if (push)
    begin
      skid_data  <= push_data;
      skid_valid <= 1'b1;
    end
  end

  // ****************************************************************
  // Write path
  // ****************************************************************

  // Write tokens; no token means write inputs are ignored
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      wr_tok <= '0;
    else
      wr_tok <= {wr_tok[`BDS_WR_DEPTH-2:0], write_go};  // RULE19 RULE18
  end

  // Write address copies follow their tokens
  always_ff @(posedge clk_i)
  begin
    wr_addr[0] <= addr_i;  // RULE14
    for (int j = 1; j < `BDS_WR_DEPTH; j++)
      wr_addr[j] <= wr_addr[j-1];
  end

  assign commit_en = wr_tok[`BDS_WR_COMMIT];

  // Collect one word per edge, both phases; set wins over commit clear
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      wvalid <= '0;
    else
    begin
      for (int k = 0; k < `BDS_BURST; k++)
      begin
        if (wr_tok[`BDS_WR_FIRST + k])
        begin
          wcol[k]      <= write_bus_i;            // RULE6 RULE15
          wsel_n[k]    <= byte_write_select_n_i;  // RULE8
          wcol_addr[k] <= wr_addr[`BDS_WR_FIRST + k];
          wvalid[k]    <= 1'b1;
        end
        else if (commit_en)
          wvalid[k] <= 1'b0;
      end
    end
  end

  // Commit the assembled burst once all four words are in
  always_ff @(posedge clk_i)
  begin
    if (commit_en)
    begin
      for (int k = 0; k < `BDS_BURST; k++)
        mem[k][wr_addr[`BDS_WR_COMMIT]] <=
          lane_merge(mem[k][wr_addr[`BDS_WR_COMMIT]], wcol[k], wsel_n[k]);  // RULE16
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_rd_pll;
    read_go && !lat_legacy ##1 in_ready [*2];
  endsequence

  sequence s_rd_legacy;
    read_go && lat_legacy ##1 in_ready;
  endsequence

  property p_read_gap;
    read_go |-> ##2 !read_go;
  endproperty
  a_read_gap: assert property (p_read_gap) else $error("read started on back-to-back rises"); // RULE11

  property p_write_gap;
    write_go |-> ##2 !write_go;
  endproperty
  a_write_gap: assert property (p_write_gap) else $error("write started on back-to-back rises"); // RULE17

  property p_read_first;
    (phase == BDS_PH_POS && !read_select_n_i && !write_select_n_i
     && !rd_hist[1] && !wr_tok[1] && in_ready) |-> read_go && !write_go;
  endproperty
  a_read_first: assert property (p_read_first) else $error("read not first from idle"); // RULE20

  property p_lat_pll;
    s_rd_pll |=> read_valid_o && !read_bus_oe_n_o;
  endproperty
  a_lat_pll: assert property (p_lat_pll) else $error("pll-mode first word late"); // RULE4

  property p_lat_legacy;
    s_rd_legacy |=> read_valid_o;
  endproperty
  a_lat_legacy: assert property (p_lat_legacy) else $error("legacy first word late"); // RULE4

  property p_tristate;
    !read_valid_o |-> read_bus_oe_n_o;
  endproperty
  a_tristate: assert property (p_tristate) else $error("read bus driven with no data"); // RULE13

  property p_commit;
    write_go |-> ##6 commit_en;
  endproperty
  a_commit: assert property (p_commit) else $error("burst not committed on time"); // RULE16

  property p_collect;
    write_go |-> ##3 wvalid[0] ##3 wvalid[3];
  endproperty
  a_collect: assert property (p_collect) else $error("write words not collected"); // RULE15

  property p_reset_idle;
    $past(srst_i) |-> read_bus_oe_n_o && !read_valid_o && wr_tok == '0;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset"); // RULE22

endmodule // bds_ports

// file: core/bds_consts.svh
// Purpose: Named constants for the burst-of-four double-rate SRAM port logic
// Assumes: One clock edge of clk_i stands for one input clock rise
// Notes:   Edges alternate between the positive and the negative input clock
`ifndef BDS_CONSTS_SVH
`define BDS_CONSTS_SVH

// ****************************************************************
// Data layout
// ****************************************************************
`define BDS_WORD_W      18
`define BDS_LANE_W      9
`define BDS_LANES       2
`define BDS_BURST       4
`define BDS_ADDR_W      18

// ****************************************************************
// Pipeline timing, in clk_i edges (half input-clock cycles)
// ****************************************************************
`define BDS_LAT_PLL     3'h2
`define BDS_LAT_LEGACY  3'h1
`define BDS_RD_DEPTH    5
`define BDS_WR_DEPTH    6
`define BDS_WR_FIRST    1
`define BDS_WR_COMMIT   5

`endif

// file: core/bds_pkg.sv
// Purpose: Shared types for the burst-of-four double-rate SRAM port logic
// Assumes: Constants come from bds_consts.svh
// Notes:   Types only
`include "bds_consts.svh"

package bds_pkg;

  // One data word of the read or write port
  typedef logic [`BDS_WORD_W-1:0] bds_word_type;

  // Which input clock the current clk_i edge stands for
  typedef enum logic [0:0]
  {
    BDS_PH_POS = 1'b0,
    BDS_PH_NEG = 1'b1
  } bds_phase_type;

endpackage

// file: bench/bds_ctrl_model.sv
// Purpose: Memory controller model facing the burst SRAM port logic
// Assumes: Next edge after reset release is a positive input clock rise
// Notes:   Commands queue up; gap counts idle positive slots before each
`timescale 1ns/1ps
`include "bds_consts.svh"

module bds_ctrl_model
  import bds_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   srst_i,
  // Towards the device
  output logic [ADDR_W-1:0]           addr_o,
  output logic                        read_select_n_o,
  output logic                        write_select_n_o,
  output logic [`BDS_LANES-1:0]       byte_write_select_n_o,
  output logic [`BDS_WORD_W-1:0]      write_bus_o,
  output logic                        read_ready_o,
  // From the device
  input  wire logic [`BDS_WORD_W-1:0] read_bus_i,
  input  wire logic                   read_valid_i
);
  typedef struct {logic rd; logic wr; logic [ADDR_W-1:0] a; bds_word_type w[4];
    logic [1:0] m[4]; int gap;} bds_cmd_type;

  bds_cmd_type  cq[$];
  bds_cmd_type  cur;
  bds_word_type rq[$];
  int           lat_q[$];
  bds_word_type sw[6];
  logic [1:0]   sm[6];
  logic         sv[6];
  logic         ph = 1'b0;
  logic         vld_d = 1'b0;
  int           ecnt = 0;
  int           rd_edge = 0;
  int           vld_rises = 0;
  int           stall = 0;

  // Time-zero levels; selects idle high
  initial
  begin
    addr_o = '0;
    read_select_n_o = 1'b1;
    write_select_n_o = 1'b1;
    byte_write_select_n_o = 2'h3;
    write_bus_o = '0;
    read_ready_o = 1'b1;
    foreach (sv[i]) sv[i] = 1'b0;
  end

  task automatic push(input logic rd, wr, input logic [ADDR_W-1:0] a,
                      input bds_word_type w[4], input logic [1:0] m[4], input int gap);
    bds_cmd_type c;
    c = '{rd, wr, a, w, m, gap};
    cq.push_back(c);
  endtask

  // Edge phase, read capture and latency
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ph <= 1'b0;
      ecnt <= 0;
      vld_d <= 1'b0;
    end
    else
    begin
      ph <= ~ph;
      ecnt <= ecnt + 1;
      vld_d <= read_valid_i;
      if (read_valid_i && read_ready_o) rq.push_back(read_bus_i);
      if (read_valid_i && !vld_d)
      begin
        vld_rises++;
        lat_q.push_back(ecnt + 1 - rd_edge);
      end
    end
  end

  // Drive on falling edges; released lines never hold their last value
  // Each pin is assigned once per edge; next levels are worked out first
  always @(negedge clk_i)
  begin
    logic              rs_n;
    logic              ws_n;
    logic [ADDR_W-1:0] ad;
    rs_n = 1'b1;
    ws_n = 1'b1;
    ad   = ~addr_o;
    for (int i = 0; i < 5; i++)
    begin
      sw[i] = sw[i+1];
      sm[i] = sm[i+1];
      sv[i] = sv[i+1];
    end
    sv[5] = 1'b0;
    read_ready_o = (stall == 0);
    if (stall > 0) stall--;
    if (!srst_i && ecnt >= 2 && !ph && cq.size() > 0)
    begin
      if (cq[0].gap > 0) cq[0].gap--;
      else
      begin
        cur = cq.pop_front();
        rs_n = ~cur.rd;
        ws_n = ~cur.wr;
        ad = cur.a;
        if (cur.rd) rd_edge = ecnt + 1;
        // A tied write loses to its read and sends no data; a refused one sends none either
        if (cur.wr && !cur.rd && !sv[2])
          for (int j = 0; j < 4; j++)
          begin
            sw[2+j] = cur.w[j];
            sm[2+j] = cur.m[j];
            sv[2+j] = 1'b1;
          end
      end
    end
    read_select_n_o = rs_n;
    write_select_n_o = ws_n;
    addr_o = ad;
    write_bus_o = sv[0] ? sw[0] : ~write_bus_o;
    byte_write_select_n_o = sv[0] ? sm[0] : ~byte_write_select_n_o;
  end
endmodule // bds_ctrl_model

// file: bench/tb_top.sv
// Purpose: Self-checking bench for the burst SRAM port logic
// Assumes: Controller model drives all requests on falling edges
// Notes:   Memory contents persist across the second reset
`timescale 1ns/1ps
`include "bds_consts.svh"

`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end

module tb_top
  import bds_pkg::*;
;
  logic                   clk_i = 1'b0;
  logic                   srst_i = 1'b1;
  logic                   pll_disable_n_i = 1'b1;
  logic [7:0]             addr_i;
  logic                   read_select_n_i, write_select_n_i, read_ready_i;
  logic [1:0]             byte_write_select_n_i;
  logic [`BDS_WORD_W-1:0] write_bus_i, read_bus_o;
  logic                   read_bus_oe_n_o, read_valid_o;
  logic [31:0]            seed = 32'hc71f;
  bds_word_type           mem[0:255][0:3];
  bds_word_type           eq[$];
  int                     err_count = 0;
  int                     n_tests = 0;
  int                     cyc = 0;

  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end

  bds_ports #(.ADDR_W(8)) dut (.clk_i(clk_i), .srst_i(srst_i),
    .pll_disable_n_i(pll_disable_n_i), .addr_i(addr_i), .read_select_n_i(read_select_n_i),
    .write_select_n_i(write_select_n_i), .byte_write_select_n_i(byte_write_select_n_i),
    .write_bus_i(write_bus_i), .read_bus_o(read_bus_o), .read_bus_oe_n_o(read_bus_oe_n_o),
    .read_valid_o(read_valid_o), .read_ready_i(read_ready_i));

  bds_ctrl_model #(.ADDR_W(8)) ctl (.clk_i(clk_i), .srst_i(srst_i), .addr_o(addr_i),
    .read_select_n_o(read_select_n_i), .write_select_n_o(write_select_n_i),
    .byte_write_select_n_o(byte_write_select_n_i), .write_bus_o(write_bus_i),
    .read_ready_o(read_ready_i), .read_bus_i(read_bus_o), .read_valid_i(read_valid_o));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Lane merge; active-low selects keep unselected lanes
  function automatic bds_word_type merge(bds_word_type o, bds_word_type n, logic [1:0] m);
    merge = o;
    if (!m[0]) merge[8:0] = n[8:0];
    if (!m[1]) merge[17:9] = n[17:9];
  endfunction

  task automatic wr(input logic [7:0] a, input int gap, input bit full, input bit keep);
    bds_word_type w[4];
    logic [1:0]   m[4];
    for (int j = 0; j < 4; j++)
    begin
      w[j] = bds_word_type'(rnd());
      m[j] = full ? 2'h0 : 2'(rnd());
      if (keep) mem[a][j] = merge(mem[a][j], w[j], m[j]);
    end
    ctl.push(1'b0, 1'b1, a, w, m, gap);
  endtask

  task automatic rd(input logic [7:0] a, input int gap, input bit keep, input bit both);
    bds_word_type w[4];
    logic [1:0]   m[4];
    for (int j = 0; j < 4; j++)
    begin
      if (keep) eq.push_back(mem[a][j]);
      w[j] = '0;
      m[j] = 2'h3;
    end
    ctl.push(1'b1, both, a, w, m, gap);
  endtask

  task automatic drain(input string nm);
    int           k;
    bds_word_type e, g;
    k = 0;
    while (ctl.cq.size() > 0 && k < 500)
    begin
      @(negedge clk_i);
      k++;
    end
    `CHK("queue drained", 0, ctl.cq.size())
    repeat (24) @(negedge clk_i);
    `CHK("word count", eq.size(), ctl.rq.size())
    while (eq.size() > 0 && ctl.rq.size() > 0)
    begin
      e = eq.pop_front();
      g = ctl.rq.pop_front();
      `CHK(nm, e, g)
    end
    eq.delete();
    ctl.rq.delete();
    $display("test %s done", nm);
  endtask

  task automatic do_reset(input logic pll);
    srst_i = 1'b1;
    pll_disable_n_i = pll;
    repeat (16) @(negedge clk_i);
    srst_i = 1'b0;
    @(negedge clk_i);
    `CHK("idle oe_n", 1'b1, read_bus_oe_n_o)
    `CHK("idle valid", 1'b0, read_valid_o)
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Output enable tracks valid data at every edge
  always @(posedge clk_i)
  begin
    cyc++;
    if (!srst_i) `CHK("oe_n", ~read_valid_o, read_bus_oe_n_o)
    if (cyc == 20000)
    begin
      err_count++;
      results();
    end
  end

  initial
  begin
    logic [7:0] a[8];
    do_reset(1'b1);
    for (int i = 0; i < 8; i++)
    begin
      a[i] = 8'(rnd());
      wr(a[i], 1, 1, 1);
    end
    for (int i = 0; i < 8; i++) rd(a[i], 1, 1, 0);
    drain("stream");
    `CHK("valid rises", 1, ctl.vld_rises)
    `CHK("latency pll", 3, ctl.lat_q[0])
    for (int i = 0; i < 8; i++) wr(a[i], 1, 0, 1);
    for (int i = 0; i < 8; i++) rd(a[i], 1, 1, 0);
    drain("masked");
    rd(a[0], 1, 1, 0);
    rd(a[1], 0, 0, 0);
    drain("read refused");
    wr(a[2], 1, 1, 1);
    wr(a[2], 0, 1, 0);
    rd(a[2], 1, 1, 0);
    drain("write refused");
    rd(a[3], 1, 1, 1);
    wr(a[3], 0, 1, 1);
    rd(a[3], 1, 1, 0);
    drain("tie");
    wr(a[4], 1, 1, 1);
    rd(a[4], 0, 1, 0);
    rd(a[4], 5, 1, 0);
    drain("forward");
    rd(a[5], 1, 1, 0);
    repeat (7) @(negedge clk_i);
    ctl.stall = 5;
    drain("stall");
    do_reset(1'b0);
    ctl.lat_q.delete();
    rd(a[6], 1, 1, 0);
    drain("legacy");
    `CHK("latency legacy", 2, ctl.lat_q[0])
    results();
  end
endmodule // tb_top
